// ---- src/vme_dpr_defines.svh ----
// Constants for the shared RAM slave port: offsets, fields, reset values, timing
`ifndef VME_DPR_DEFINES_SVH
`define VME_DPR_DEFINES_SVH

// ----------------------------------------------------------------
// Shared RAM geometry
// ----------------------------------------------------------------
`define RAM_AW          16
`define RAM_WORDS       65536
`define BASE_W          7
`define BASE_LSB        17

// ----------------------------------------------------------------
// Dedicated word addresses inside the shared RAM window
// ----------------------------------------------------------------
`define MBOX_RESET_WA   16'hFFFE
`define MBOX_IRQ_WA     16'hFFFC
`define IRQ_CFG_WA      16'hFFF0
`define IRQ_CFG_MASK    16'hFFFC

// ----------------------------------------------------------------
// Interrupter channel word layout
// ----------------------------------------------------------------
`define VEC_LSB         0
`define VEC_MSB         7
`define LVL_LSB         8
`define LVL_MSB         10
`define IRQ_CH          4
`define LVL_RST         3'h0
`define VEC_RST         8'h0F

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ         250
`define LP_CLK_MHZ      10
`define LP_DIV          (`CLK_MHZ / `LP_CLK_MHZ)
`define LP_RESET_NS     1000
`define LP_RESET_CYC    ((`LP_RESET_NS * `CLK_MHZ + 999) / 1000)

`endif

// ---- src/vme_dpr_pkg.sv ----
// Types shared by the shared RAM slave port
package vme_dpr_pkg;

  // VME cycle sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT,
    ST_IACK,
    ST_ACK,
    ST_PASS
  } vme_state_t;

  typedef logic [2:0] irq_level_t;
  typedef logic [7:0] irq_vector_t;

endpackage : vme_dpr_pkg

// ---- src/vme_dpr_slave_mailbox.sv ----
// VMEbus A24/D16 slave into shared RAM with mailboxes and a bus interrupter
`timescale 1ns/1ps
`include "vme_dpr_defines.svh"

// Overview of operation
// R1: Answer A24 cycles, byte and word data
// R2: Base address and AM codes from straps
// R3: SYSFAIL held until initialization completes
// R4: Reset word access resets local processor
// R5: Interrupt word access interrupts local processor
// R6: Four interrupter channels drive VME requests
// R7: Each channel holds level 1-7, vector
// R8: Local sets requests, host programs channels
// R9: Local processor always wins shared RAM
// R10: VME access fits between local cycles
// R11: SYSRESET resets local processor and devices
// R12: DTACK only after RAM access completed
// R13: Host holds signals stable until DTACK
module vme_dpr_slave_mailbox
  import vme_dpr_pkg::*;
(
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst,
  // VMEbus pins
  input  wire logic [23:1]          i_vme_addr,
  input  wire logic [5:0]           i_vme_am,
  input  wire logic                 i_vme_as_n,
  input  wire logic                 i_vme_ds0_n,
  input  wire logic                 i_vme_ds1_n,
  input  wire logic                 i_vme_write_n,
  input  wire logic                 i_vme_iack_n,
  input  wire logic                 i_vme_iackin_n,
  input  wire logic                 i_vme_sysreset_n,
  input  wire logic [15:0]          i_vme_data,
  output logic      [15:0]          o_vme_data,
  output logic                      o_vme_data_oe,
  output logic                      o_vme_dtack_n,
  output logic                      o_vme_sysfail_n,
  output logic      [7:1]           o_vme_irq_n,
  output logic                      o_vme_iackout_n,
  // Installation straps
  input  wire logic [`BASE_W-1:0]   i_base_addr,
  input  wire logic [5:0]           i_am_code_a,
  input  wire logic [5:0]           i_am_code_b,
  // Local processor side
  input  wire logic                 i_lp_req,
  input  wire logic                 i_lp_we,
  input  wire logic [1:0]           i_lp_be,
  input  wire logic [`RAM_AW-1:0]   i_lp_addr,
  input  wire logic [15:0]          i_lp_wdata,
  output logic      [15:0]          o_lp_rdata,
  output logic                      o_lp_slot,
  output logic                      o_lp_reset,
  output logic                      o_lp_irq,
  input  wire logic                 i_lp_irq_ack,
  input  wire logic                 i_init_done,
  input  wire logic [`IRQ_CH-1:0]   i_irq_set
);

  localparam int SW = 52;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte lane merge: be[1] upper byte, be[0] lower byte
  function automatic logic [15:0] lane_merge(input logic [15:0] old_w,
                                             input logic [15:0] new_w,
                                             input logic [1:0]  be);
    lane_merge = {be[1] ? new_w[15:8] : old_w[15:8], be[0] ? new_w[7:0] : old_w[7:0]};
  endfunction : lane_merge

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SW-1:0] s1_ff;
  logic [SW-1:0] s2_ff;
  logic [SW-1:0] s3_ff;
  logic [SW-1:0] flt_ff;
  logic [SW-1:0] pins;

  assign pins = {i_vme_addr, i_vme_am, i_vme_as_n, i_vme_ds0_n, i_vme_ds1_n,
                 i_vme_write_n, i_vme_iack_n, i_vme_iackin_n, i_vme_sysreset_n,
                 i_vme_data};

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s1_ff  <= '1;
      s2_ff  <= '1;
      s3_ff  <= '1;
      flt_ff <= '1;
    end else begin
      s1_ff  <= pins;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      flt_ff <= (s2_ff & ~(s2_ff ^ s3_ff)) | (flt_ff & (s2_ff ^ s3_ff));
    end
  end

  logic [23:1] v_addr;
  logic [5:0]  v_am;
  logic        v_as_n, v_ds0_n, v_ds1_n, v_write_n, v_iack_n, v_iackin_n, v_sysrst_n;
  logic [15:0] v_data;

  assign {v_addr, v_am, v_as_n, v_ds0_n, v_ds1_n, v_write_n, v_iack_n, v_iackin_n,
          v_sysrst_n, v_data} = flt_ff;

  // ----------------------------------------------------------------
  // Local processor clock enable
  // ----------------------------------------------------------------
  logic [4:0] div_ff;
  logic       lp_en;

  assign lp_en = (div_ff == 5'(`LP_DIV - 1));

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      div_ff <= 5'h00;
    end else begin
      div_ff <= lp_en ? 5'h00 : div_ff + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic ds_any;
  logic am_ok;
  logic hit;

  assign ds_any = ~v_ds0_n | ~v_ds1_n;
  assign am_ok  = (v_am == i_am_code_a) | (v_am == i_am_code_b); // R2
  assign hit    = ~v_as_n & ds_any & v_iack_n & am_ok
                & (v_addr[23:`BASE_LSB] == i_base_addr); // R1 R2

  // ----------------------------------------------------------------
  // VME cycle sequencer
  // ----------------------------------------------------------------
  vme_state_t          state_ff;
  logic [`RAM_AW-1:0]  cyc_addr_ff;
  logic [15:0]         cyc_data_ff;
  logic [1:0]          cyc_be_ff;
  logic                cyc_we_ff;
  logic                vme_slot;
  logic [15:0]         mem [`RAM_WORDS];
  logic [`IRQ_CH-1:0]  pend_ff;
  irq_level_t          lvl_ff [`IRQ_CH];
  irq_vector_t         vec_ff [`IRQ_CH];
  logic                ack_hit;
  logic [1:0]          ack_ch;
  logic                sys_rst;

  assign sys_rst  = ~v_sysrst_n;
  // VME gets the slot only when the local processor leaves it free
  assign vme_slot = (state_ff == ST_WAIT) & lp_en & ~i_lp_req; // R9 R10

  // Acknowledge match: lowest channel pending at the requested level
  always_comb begin
    ack_hit = 1'b0;
    ack_ch  = 2'h0;
    for (int c = `IRQ_CH - 1; c >= 0; c--) begin
      if (pend_ff[c] && lvl_ff[c] == v_addr[3:1] && lvl_ff[c] != 3'h0) begin
        ack_hit = 1'b1;
        ack_ch  = 2'(c);
      end
    end
  end

  // Sequencer state and captured cycle
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_ff    <= ST_IDLE;
      cyc_addr_ff <= '0;
      cyc_data_ff <= 16'h0000;
      cyc_be_ff   <= 2'h0;
      cyc_we_ff   <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (hit) begin
            state_ff    <= ST_WAIT;
            cyc_addr_ff <= v_addr[16:1];
            cyc_data_ff <= v_data; // R13
            cyc_be_ff   <= {~v_ds1_n, ~v_ds0_n}; // R1
            cyc_we_ff   <= ~v_write_n;
          end else if (~v_as_n & ~v_ds0_n & ~v_iack_n & ~v_iackin_n) begin
            state_ff <= ST_IACK;
          end
        end
        ST_WAIT: begin
          if (vme_slot) begin
            state_ff <= ST_ACK;
          end
        end
        ST_IACK: begin
          state_ff <= ack_hit ? ST_ACK : ST_PASS;
        end
        ST_ACK: begin
          if (v_ds0_n & v_ds1_n) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_PASS: begin
          if (v_as_n) begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // VME bus outputs: DTACK follows the completed RAM access
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_vme_dtack_n   <= 1'b1;
      o_vme_data_oe   <= 1'b0;
      o_vme_data      <= 16'h0000;
      o_vme_iackout_n <= 1'b1;
    end else begin
      if (vme_slot) begin
        o_vme_dtack_n <= 1'b0; // R12
        o_vme_data_oe <= ~cyc_we_ff;
        o_vme_data    <= mem[cyc_addr_ff];
      end else if (state_ff == ST_IACK && ack_hit) begin
        o_vme_dtack_n <= 1'b0;
        o_vme_data_oe <= 1'b1;
        o_vme_data    <= {8'h00, vec_ff[ack_ch]}; // R7
      end else if (state_ff == ST_ACK && v_ds0_n && v_ds1_n) begin
        o_vme_dtack_n <= 1'b1;
        o_vme_data_oe <= 1'b0;
      end
      // Pass the acknowledge down the daisy chain when not ours
      if (state_ff == ST_IACK && !ack_hit) begin
        o_vme_iackout_n <= 1'b0;
      end else if (state_ff == ST_PASS && v_as_n) begin
        o_vme_iackout_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared RAM: one access per local processor slot
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (lp_en && i_lp_req && i_lp_we) begin
      mem[i_lp_addr] <= lane_merge(mem[i_lp_addr], i_lp_wdata, i_lp_be); // R9
    end else if (vme_slot && cyc_we_ff) begin
      mem[cyc_addr_ff] <= lane_merge(mem[cyc_addr_ff], cyc_data_ff, cyc_be_ff); // R10
    end
  end

  // Local processor read data and slot marker
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_lp_rdata <= 16'h0000;
      o_lp_slot  <= 1'b0;
    end else begin
      o_lp_slot <= lp_en;
      if (lp_en && i_lp_req && !i_lp_we) begin
        o_lp_rdata <= mem[i_lp_addr];
      end
    end
  end

  // ----------------------------------------------------------------
  // Mailboxes, local reset and SYSFAIL
  // ----------------------------------------------------------------
  logic        mbox_rst;
  logic        mbox_irq;
  logic [11:0] rst_cnt_ff;

  assign mbox_rst = vme_slot & (cyc_addr_ff == `MBOX_RESET_WA);
  assign mbox_irq = vme_slot & (cyc_addr_ff == `MBOX_IRQ_WA);

  // Local reset stretch, restarted by either reset source
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rst_cnt_ff <= 12'(`LP_RESET_CYC);
      o_lp_reset <= 1'b1;
    end else begin
      if (mbox_rst || sys_rst) begin
        rst_cnt_ff <= 12'(`LP_RESET_CYC); // R4 R11
      end else if (rst_cnt_ff != 12'h000) begin
        rst_cnt_ff <= rst_cnt_ff - 12'h001;
      end
      o_lp_reset <= mbox_rst | sys_rst | (rst_cnt_ff > 12'h001);
    end
  end

  // Local interrupt flag; a new access wins over the acknowledge
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_lp_irq <= 1'b0;
    end else if (mbox_irq) begin
      o_lp_irq <= 1'b1; // R5
    end else if (i_lp_irq_ack || o_lp_reset) begin
      o_lp_irq <= 1'b0;
    end
  end

  // SYSFAIL asserted from every reset until initialization reports done
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_vme_sysfail_n <= 1'b0;
    end else if (mbox_rst || sys_rst || o_lp_reset) begin
      o_vme_sysfail_n <= 1'b0; // R3
    end else if (i_init_done) begin
      o_vme_sysfail_n <= 1'b1; // R3
    end
  end

  // ----------------------------------------------------------------
  // Bus interrupter
  // ----------------------------------------------------------------
  logic cfg_wr;

  assign cfg_wr = vme_slot & cyc_we_ff & ((cyc_addr_ff & `IRQ_CFG_MASK) == `IRQ_CFG_WA);

  // Host-programmed level and vector per channel
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int c = 0; c < `IRQ_CH; c++) begin
        lvl_ff[c] <= `LVL_RST;
        vec_ff[c] <= `VEC_RST;
      end
    end else if (cfg_wr) begin
      if (cyc_be_ff[1]) begin
        lvl_ff[cyc_addr_ff[1:0]] <= cyc_data_ff[`LVL_MSB:`LVL_LSB]; // R7 R8
      end
      if (cyc_be_ff[0]) begin
        vec_ff[cyc_addr_ff[1:0]] <= cyc_data_ff[`VEC_MSB:`VEC_LSB]; // R7 R8
      end
    end
  end

  // Pending requests: local sets, acknowledge clears, set wins
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pend_ff <= '0;
    end else begin
      for (int c = 0; c < `IRQ_CH; c++) begin
        if (i_irq_set[c]) begin
          pend_ff[c] <= 1'b1; // R8
        end else if (sys_rst || (state_ff == ST_IACK && ack_hit && ack_ch == 2'(c))) begin
          pend_ff[c] <= 1'b0;
        end
      end
    end
  end

  // Request lines, one per level, each channel at its own level
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_vme_irq_n <= 7'h7F;
    end else begin
      for (int l = 1; l <= 7; l++) begin
        o_vme_irq_n[l] <= 1'b1;
        for (int c = 0; c < `IRQ_CH; c++) begin
          if (pend_ff[c] && lvl_ff[c] == 3'(l)) begin
            o_vme_irq_n[l] <= 1'b0; // R6
          end
        end
      end
    end
  end

endmodule : vme_dpr_slave_mailbox

// ---- sim/vme_dpr_slave_mailbox_monitor.sv ----
// Concurrent checks on the shared RAM slave port pins
`timescale 1ns/1ps
module vme_dpr_slave_mailbox_monitor (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_vme_ds0_n,
  input wire logic i_vme_ds1_n,
  input wire logic i_vme_iack_n,
  input wire logic i_vme_sysreset_n,
  input wire logic i_lp_req,
  input wire logic o_vme_dtack_n,
  input wire logic o_vme_data_oe,
  input wire logic o_vme_sysfail_n,
  input wire logic o_lp_slot,
  input wire logic o_lp_reset,
  input wire logic o_lp_irq
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------
  sequence s_data_ack;
    $fell(o_vme_dtack_n) && $past(i_vme_iack_n);
  endsequence
  sequence s_reset_held;
    o_lp_reset[*8];
  endsequence
  property p_fail_in_reset;
    o_lp_reset |-> !o_vme_sysfail_n;
  endproperty
  property p_sysreset;
    !i_vme_sysreset_n[*6] |-> o_lp_reset;
  endproperty
  property p_local_first;
    s_data_ack |-> !$past(i_lp_req);
  endproperty
  property p_ack_hold;
    !o_vme_dtack_n && !(i_vme_ds0_n && i_vme_ds1_n) |=> !o_vme_dtack_n;
  endproperty
  property p_ack_release;
    $rose(i_vme_ds0_n && i_vme_ds1_n) |-> ##[1:8] o_vme_dtack_n;
  endproperty
  property p_oe_with_ack;
    o_vme_data_oe |-> !o_vme_dtack_n;
  endproperty
  property p_irq_with_ack;
    $rose(o_lp_irq) |-> !o_vme_dtack_n;
  endproperty
  property p_reset_pulse;
    $rose(o_lp_reset) |-> s_reset_held;
  endproperty
  property p_slot_period;
    o_lp_slot |=> (!o_lp_slot)[*8] ##17 o_lp_slot;
  endproperty
  a_fail_in_reset: assert property (p_fail_in_reset)
    else $error("sysfail released during local reset");
  a_sysreset: assert property (p_sysreset)
    else $error("system reset did not reset local side");
  a_local_first: assert property (p_local_first)
    else $error("bus answered in a local slot");
  a_ack_hold: assert property (p_ack_hold)
    else $error("dtack dropped while strobes low");
  a_ack_release: assert property (p_ack_release)
    else $error("dtack not released after strobes");
  a_oe_with_ack: assert property (p_oe_with_ack)
    else $error("data driven without dtack");
  a_irq_with_ack: assert property (p_irq_with_ack)
    else $error("local irq raised outside bus answer");
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("local reset pulse too short");
  a_slot_period: assert property (p_slot_period)
    else $error("local slot spacing wrong");
endmodule : vme_dpr_slave_mailbox_monitor

bind vme_dpr_slave_mailbox vme_dpr_slave_mailbox_monitor mon (.i_mclk, .i_rst, .i_vme_ds0_n,
  .i_vme_ds1_n, .i_vme_iack_n, .i_vme_sysreset_n, .i_lp_req, .o_vme_dtack_n, .o_vme_data_oe,
  .o_vme_sysfail_n, .o_lp_slot, .o_lp_reset, .o_lp_irq);

// ---- sim/vme_host_model.sv ----
// Host bus master model driving the slave port pins
`timescale 1ns/1ps
module vme_host_model (
  input  wire logic        i_mclk,
  input  wire logic        i_dtack_n,
  input  wire logic [15:0] i_rdata,
  output logic      [23:1] o_addr,
  output logic      [5:0]  o_am,
  output logic             o_as_n,
  output logic             o_ds0_n,
  output logic             o_ds1_n,
  output logic             o_write_n,
  output logic             o_iack_n,
  output logic             o_iackin_n,
  output logic      [15:0] o_data
);
  initial begin
    {o_addr, o_am, o_data} = '0;
    {o_as_n, o_ds0_n, o_ds1_n, o_write_n, o_iack_n, o_iackin_n} = 6'h3F;
  end
  // One bus cycle; all pins held until dtack is sampled low or lim edges pass
  task automatic cycle(input logic [23:1] a, input logic [5:0] am, input logic wr,
                       input logic [1:0] ds, input logic ia, input logic [15:0] wd,
                       input int dly, input int lim, output logic ok, output logic [15:0] rd);
    int n;
    n = 0;
    repeat (dly) @(posedge i_mclk);
    o_addr <= a;
    o_am <= am;
    o_write_n <= ~wr;
    o_iack_n <= ~ia;
    o_iackin_n <= ~ia;
    o_as_n <= 1'h0;
    {o_ds1_n, o_ds0_n} <= ~ds;
    if (wr)
      o_data <= wd;
    @(posedge i_mclk);
    while (i_dtack_n !== 1'h0 && n < lim) begin
      n++;
      @(posedge i_mclk);
    end
    ok = (i_dtack_n === 1'h0);
    rd = i_rdata;
    // Release; the data lines show the inverse of their last value
    {o_as_n, o_ds0_n, o_ds1_n, o_iack_n, o_iackin_n} <= 5'h1F;
    o_data <= ~o_data;
    // Let the release stand until dtack is sampled high before any new request
    @(posedge i_mclk);
    while (i_dtack_n !== 1'h1 && n < lim + 20) begin
      n++;
      @(posedge i_mclk);
    end
  endtask : cycle
endmodule : vme_host_model

// ---- sim/tb_top.sv ----
// Self-checking bench for the shared RAM slave port
`timescale 1ns/1ps
module tb_top;
  localparam logic [6:0] BASE = 7'h2A;
  localparam logic [5:0] AM_A = 6'h39;
  localparam logic [5:0] AM_B = 6'h3D;
  logic        i_mclk = 1'h0, i_rst = 1'h1, sysreset_n = 1'h1, lp_req = 1'h0, busy = 1'h0;
  logic        lp_irq_ack = 1'h0, init_done = 1'h0, dtack_ff = 1'h1, ok;
  logic        as_n, ds0_n, ds1_n, write_n, iack_n, iackin_n, dtack_n, data_oe;
  logic        sysfail_n, iackout_n, lp_slot, lp_reset, lp_irq;
  logic [15:0] lp_addr = 16'h0, wdata, rdata, lp_rdata, rd;
  logic [3:0]  irq_set = 4'h0;
  logic [23:1] vaddr;
  logic [5:0]  vam;
  logic [7:1]  irq_n;
  logic [2:0]  lvl;
  logic [15:0] exp_q[$];
  int          num_errors = 0, total_checks = 0, cyc = 0, seed = 14;

  always #2 i_mclk = ~i_mclk;

  vme_dpr_slave_mailbox dut (.i_mclk, .i_rst, .i_vme_addr(vaddr), .i_vme_am(vam),
    .i_vme_as_n(as_n), .i_vme_ds0_n(ds0_n), .i_vme_ds1_n(ds1_n), .i_vme_write_n(write_n),
    .i_vme_iack_n(iack_n), .i_vme_iackin_n(iackin_n), .i_vme_sysreset_n(sysreset_n),
    .i_vme_data(wdata), .o_vme_data(rdata), .o_vme_data_oe(data_oe), .o_vme_dtack_n(dtack_n),
    .o_vme_sysfail_n(sysfail_n), .o_vme_irq_n(irq_n), .o_vme_iackout_n(iackout_n),
    .i_base_addr(BASE), .i_am_code_a(AM_A), .i_am_code_b(AM_B), .i_lp_req(lp_req),
    .i_lp_we(1'h0), .i_lp_be(2'h3), .i_lp_addr(lp_addr), .i_lp_wdata(16'h0),
    .o_lp_rdata(lp_rdata), .o_lp_slot(lp_slot), .o_lp_reset(lp_reset), .o_lp_irq(lp_irq),
    .i_lp_irq_ack(lp_irq_ack), .i_init_done(init_done), .i_irq_set(irq_set));

  vme_host_model host (.i_mclk, .i_dtack_n(dtack_n), .i_rdata(rdata), .o_addr(vaddr),
    .o_am(vam), .o_as_n(as_n), .o_ds0_n(ds0_n), .o_ds1_n(ds1_n), .o_write_n(write_n),
    .o_iack_n(iack_n), .o_iackin_n(iackin_n), .o_data(wdata));

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // Hang guard
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // Random local reads competing for the shared RAM
  always @(posedge i_mclk) begin
    lp_req <= busy && ($random(seed) % 3 == 0);
    lp_addr <= 16'($random(seed));
  end

  // Each answered cycle that drives data (read or acknowledge) pops the oldest expectation
  always @(posedge i_mclk) begin
    if (!i_rst && dtack_ff === 1'h1 && dtack_n === 1'h0 && data_oe === 1'h1)
      cmp("bus data", exp_q.size() ? exp_q.pop_front() : 16'hDEAD, rdata);
    dtack_ff <= dtack_n;
  end

  task automatic boot;
    int n = 0;
    while (lp_reset !== 1'h0 && n < 400) begin
      n++;
      @(posedge i_mclk);
    end
    cmp("sysfail_n", 16'h0, sysfail_n);
    init_done <= 1'h1;
    @(posedge i_mclk);
    init_done <= 1'h0;
    repeat (3) @(posedge i_mclk);
    cmp("sysfail_n", 16'h1, sysfail_n);
    $display("Test boot done");
  endtask : boot

  task automatic acc(input logic [6:0] b, input logic [15:0] wa, input logic [5:0] am,
                     input logic wr, input logic [1:0] ds, input logic [15:0] wd,
                     input logic ok_exp);
    host.cycle({b, wa}, am, wr, ds, 1'h0, wd, $random(seed) & 3, ok_exp ? 300 : 60, ok, rd);
    cmp("dtack", {15'h0, ok_exp}, {15'h0, ok});
  endtask : acc

  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'h0;
    @(posedge i_mclk);
    cmp("lp_reset", 16'h1, lp_reset);
    boot();
    busy <= 1'h1;
    // Word and upper byte lane under both modifier codes
    acc(BASE, 16'h1234, AM_A, 1'h1, 2'h3, 16'hA55A, 1'h1);
    acc(BASE, 16'h1234, AM_B, 1'h1, 2'h2, 16'h3C77, 1'h1);
    exp_q.push_back(16'h3C5A);
    acc(BASE, 16'h1234, AM_B, 1'h0, 2'h3, 16'h0, 1'h1);
    // Foreign modifier or base goes unanswered
    acc(BASE, 16'h1234, 6'h29, 1'h0, 2'h3, 16'h0, 1'h0);
    acc(BASE + 7'h1, 16'h1234, AM_A, 1'h0, 2'h3, 16'h0, 1'h0);
    $display("Test data path done");
    // Interrupt mailbox then local acknowledge
    acc(BASE, 16'hFFFC, AM_A, 1'h1, 2'h3, 16'h0, 1'h1);
    cmp("lp_irq", 16'h1, lp_irq);
    lp_irq_ack <= 1'h1;
    @(posedge i_mclk);
    lp_irq_ack <= 1'h0;
    repeat (2) @(posedge i_mclk);
    cmp("lp_irq", 16'h0, lp_irq);
    // Program each channel, raise it, acknowledge it
    for (int ch = 0; ch < 4; ch++) begin
      lvl = 3'(2 * ch + 1);
      acc(BASE, 16'hFFF0 + 16'(ch), AM_A, 1'h1, 2'h3, {5'h0, lvl, 8'h40 + 8'(ch)}, 1'h1);
      irq_set <= 4'h1 << ch;
      @(posedge i_mclk);
      irq_set <= 4'h0;
      repeat (4) @(posedge i_mclk);
      cmp("irq line", 16'h0, {15'h0, irq_n[lvl]});
      exp_q.push_back({8'h00, 8'h40 + 8'(ch)});
      host.cycle({20'h0, lvl}, AM_A, 1'h0, 2'h1, 1'h1, 16'h0, 0, 300, ok, rd);
      cmp("irq line", 16'h1, {15'h0, irq_n[lvl]});
      cmp("iackout_n", 16'h1, {15'h0, iackout_n});
    end
    $display("Test interrupter done");
    // Reset mailbox
    acc(BASE, 16'hFFFE, AM_B, 1'h1, 2'h3, 16'h0, 1'h1);
    cmp("lp_reset", 16'h1, lp_reset);
    cmp("sysfail_n", 16'h0, sysfail_n);
    boot();
    // Bus system reset
    sysreset_n <= 1'h0;
    repeat (10) @(posedge i_mclk);
    cmp("lp_reset", 16'h1, lp_reset);
    cmp("sysfail_n", 16'h0, sysfail_n);
    sysreset_n <= 1'h1;
    boot();
    cmp("queue left", 16'h0, 16'(exp_q.size()));
    tally_and_finish();
  end
endmodule : tb_top
